// *** rtl/pslv_pkg.sv ***
/*
 * Shared constants and types of the power slave unit control logic.
 * Assumes a 125 MHz core clock; all counts are derived from it here.
 */
package pslv_pkg;

    localparam int CLK_NS = 8;

    // Most units on one bus pair, and widths that follow from it.
    localparam int UNITS_MAX = 4;
    localparam int ID_W = 2;
    localparam int CNT_W = 3;
    localparam int MEAS_W = 8;
    localparam int SWC_W = 10;
    localparam int ADC_W = 8;

    // Identification reading: mode flag and identifier field positions.
    localparam int ADC_MODE_BIT = 7;
    localparam int ADC_ID_LSB = 5;

    // Control line held low for this long means the unit is disabled.
    localparam int T_DIS_NS = 2000;
    localparam logic [MEAS_W-1:0] DIS_CYC =
        MEAS_W'((T_DIS_NS + CLK_NS - 1) / CLK_NS);

    // Settling time of the identification current before sampling.
    localparam int T_ID_SETTLE_NS = 20000;
    localparam logic [11:0] ID_SETTLE_CYC =
        12'((T_ID_SETTLE_NS + CLK_NS - 1) / CLK_NS);

    // Accepted timing-line periods: active band near 4 MHz, idle near 1 MHz.
    localparam int T_ACT_MIN_NS = 238;
    localparam int T_ACT_MAX_NS = 270;
    localparam int T_IDLE_MIN_NS = 900;
    localparam int T_IDLE_MAX_NS = 1100;
    localparam logic [MEAS_W-1:0] ACT_MIN_CYC =
        MEAS_W'((T_ACT_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [MEAS_W-1:0] ACT_MAX_CYC = MEAS_W'(T_ACT_MAX_NS / CLK_NS);
    localparam logic [MEAS_W-1:0] IDLE_MIN_CYC =
        MEAS_W'((T_IDLE_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [MEAS_W-1:0] IDLE_MAX_CYC =
        MEAS_W'(T_IDLE_MAX_NS / CLK_NS);

    // Duty-cycle window in percent.
    localparam logic [15:0] DUTY_SCALE = 16'h0064;
    localparam logic [15:0] DUTY_MIN_PCT = 16'h0011;
    localparam logic [15:0] DUTY_MAX_PCT = 16'h0053;

    // Control-line frame: start bit, operation, argument, reply slots.
    localparam int OP_W = 2;
    localparam int ARG_W = 3;
    localparam logic [OP_W-1:0] OP_QUERY = 2'h1;
    localparam logic [OP_W-1:0] OP_COUNT = 2'h2;
    localparam logic [OP_W-1:0] OP_SHED = 2'h3;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_START,
        ST_IDLE,
        ST_OP,
        ST_ARG,
        ST_RESP
    } pslv_st_e;

endpackage

// *** rtl/pslv_id_if.sv ***
/*
 * Hand-shake between the phase control and the identifier decoder.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
interface pslv_id_if;
    import pslv_pkg::*;
    logic start;
    logic done;
    logic integ;
    logic [ID_W-1:0] id;
    modport ctl (output start, input done, input integ, input id);
    modport dec (input start, output done, output integ, output id);
endinterface

// *** rtl/pslv_pin_sync.sv ***
/*
 * Three-stage synchroniser for one pin; the output only follows once the
 * second and third stages agree. Assumes an asynchronous pin input.
 */
`timescale 1ns/1ps
module pslv_pin_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin,
    output logic q_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic q_d;

    always_comb begin
        q_d = q_q;
        if (s2_q == s3_q) begin
            q_d = s2_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            q_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_q <= q_d;
        end
    end
endmodule

// *** rtl/pslv_id_decode.sv ***
/*
 * Identifier decoder: drives the current source into the identification
 * pin, waits for the voltage to settle and decodes the converted reading.
 * Assumes the converter code is synchronous to clk.
 */
`timescale 1ns/1ps
module pslv_id_decode (
    input wire logic clk,
    input wire logic rst_b,
    pslv_id_if.dec idp,
    input wire logic [pslv_pkg::ADC_W-1:0] adc_code,
    output logic src_en_q
);
    import pslv_pkg::*;

    logic [11:0] cnt_q, cnt_d;
    logic done_q, done_d;
    logic integ_q, integ_d;
    logic [ID_W-1:0] id_q, id_d;
    logic src_en_d;

    assign idp.done = done_q;
    assign idp.integ = integ_q;
    assign idp.id = id_q;

    always_comb begin
        cnt_d = cnt_q;
        done_d = done_q;
        integ_d = integ_q;
        id_d = id_q;
        src_en_d = 1'b0;
        if (!idp.start) begin
            cnt_d = 12'h000;
            done_d = 1'b0;
        end else if (!done_q) begin
            src_en_d = 1'b1;
            if (cnt_q == ID_SETTLE_CYC - 12'h001) begin
                src_en_d = 1'b0;
                done_d = 1'b1;
                integ_d = adc_code[ADC_MODE_BIT];
                // Integrated-controller mode forces one shared identifier.
                id_d = adc_code[ADC_MODE_BIT] ? '0 :
                    adc_code[ADC_ID_LSB +: ID_W];
            end else begin
                cnt_d = cnt_q + 12'h001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 12'h000;
            done_q <= 1'b0;
            integ_q <= 1'b0;
            id_q <= '0;
            src_en_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done_q <= done_d;
            integ_q <= integ_d;
            id_q <= id_d;
            src_en_q <= src_en_d;
        end
    end
endmodule

// *** rtl/pslv_phase_ctrl.sv ***
/*
 * Control side of a current-source power slave on a two-wire bus: enable,
 * identification, query answer, count broadcast, phase placement, current
 * command and phase shedding. Assumes both bus lines are asynchronous pins
 * and that the open-drain wire is resolved outside from the enable.
 */
`timescale 1ns/1ps
module pslv_phase_ctrl #(
    parameter int MAX_UNITS = pslv_pkg::UNITS_MAX
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic timing_duty_line,
    input wire logic ctrl_handshake_line_i,
    output logic ctrl_handshake_line_o,
    output logic ctrl_handshake_line_oe,
    input wire logic [pslv_pkg::ADC_W-1:0] id_adc_code,
    output logic id_src_en,
    output logic switch_node_hs,
    output logic switch_node_ls,
    output logic [pslv_pkg::MEAS_W-1:0] cur_cmd,
    output logic enabled,
    output logic configured
);
    import pslv_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and identifier decoder.

    logic dif_f;
    logic dio_f;
    pslv_id_if idc ();

    pslv_pin_sync u_dif_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin(timing_duty_line),
        .q_q(dif_f)
    );

    pslv_pin_sync u_dio_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin(ctrl_handshake_line_i),
        .q_q(dio_f)
    );

    pslv_id_decode u_id (
        .clk(clk),
        .rst_b(rst_b),
        .idp(idc.dec),
        .adc_code(id_adc_code),
        .src_en_q(id_src_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // Timing-line measurement and cycle qualification.

    logic dif_p_q, dif_p_d;
    logic [MEAS_W-1:0] per_cnt_q, per_cnt_d;
    logic [MEAS_W-1:0] hi_cnt_q, hi_cnt_d;
    logic [MEAS_W-1:0] hi_len_q, hi_len_d;
    logic [MEAS_W-1:0] per_q, per_d;
    logic [MEAS_W-1:0] cur_d;
    logic act_clk_q, act_clk_d;
    logic rise, fall, act_ok, idle_ok, duty_ok, vrise, vfall, arise;
    logic [15:0] hi_pct, per_min, per_max;

    always_comb begin
        rise = dif_f & ~dif_p_q;
        fall = ~dif_f & dif_p_q;
        dif_p_d = dif_f;
        act_ok = per_cnt_q >= ACT_MIN_CYC && per_cnt_q <= ACT_MAX_CYC;
        idle_ok = per_cnt_q >= IDLE_MIN_CYC && per_cnt_q <= IDLE_MAX_CYC;
        hi_pct = 16'(hi_len_q) * DUTY_SCALE;
        per_min = 16'(per_cnt_q) * DUTY_MIN_PCT;
        per_max = 16'(per_cnt_q) * DUTY_MAX_PCT;
        duty_ok = hi_pct >= per_min && hi_pct <= per_max;
        // A cycle with a bad period or duty cycle is simply skipped.
        vrise = rise && (act_ok || idle_ok) && duty_ok;
        arise = vrise && act_ok;
        vfall = fall && hi_cnt_q > 8'h01;
        per_cnt_d = rise ? 8'h01 :
            (per_cnt_q == 8'hff ? per_cnt_q : per_cnt_q + 8'h01);
        hi_cnt_d = hi_cnt_q;
        if (rise) begin
            hi_cnt_d = 8'h01;
        end else if (dif_f && hi_cnt_q != 8'hff) begin
            hi_cnt_d = hi_cnt_q + 8'h01;
        end
        hi_len_d = vfall ? hi_cnt_q : hi_len_q;
        per_d = arise ? per_cnt_q : per_q;
        cur_d = arise ? hi_len_q : cur_cmd;
        act_clk_d = act_clk_q;
        if (vrise) begin
            act_clk_d = act_ok;
        end else if (per_cnt_q == 8'hff) begin
            act_clk_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dif_p_q <= 1'b0;
            per_cnt_q <= 8'hff;
            hi_cnt_q <= 8'h00;
            hi_len_q <= 8'h00;
            per_q <= 8'h00;
            cur_cmd <= 8'h00;
            act_clk_q <= 1'b0;
        end else begin
            dif_p_q <= dif_p_d;
            per_cnt_q <= per_cnt_d;
            hi_cnt_q <= hi_cnt_d;
            hi_len_q <= hi_len_d;
            per_q <= per_d;
            cur_cmd <= cur_d;
            act_clk_q <= act_clk_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Master enable from the control-line level.

    logic [MEAS_W-1:0] dis_cnt_q, dis_cnt_d;
    logic en_d;

    always_comb begin
        dis_cnt_d = 8'h00;
        en_d = enabled;
        if (dio_f) begin
            en_d = 1'b1;
        end else if (dis_cnt_q == DIS_CYC - 8'h01) begin
            en_d = 1'b0;
            dis_cnt_d = dis_cnt_q;
        end else begin
            dis_cnt_d = dis_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dis_cnt_q <= 8'h00;
            enabled <= 1'b0;
        end else begin
            dis_cnt_q <= dis_cnt_d;
            enabled <= en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control-line frame engine, stepped by qualified timing rises.

    pslv_st_e st_q, st_d;
    logic [1:0] bit_q, bit_d;
    logic [OP_W-1:0] op_q, op_d;
    logic [ARG_W-1:0] arg_q, arg_d;
    logic [ID_W-1:0] slot_q, slot_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic cfg_d, act_q, act_d, oe_d;
    logic [ARG_W-1:0] arg_n;

    assign idc.start = st_q != ST_OFF && en_d;

    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        op_d = op_q;
        arg_d = arg_q;
        slot_d = slot_q;
        cnt_d = cnt_q;
        cfg_d = configured;
        act_d = act_q;
        oe_d = ctrl_handshake_line_oe;
        arg_n = {arg_q[ARG_W-2:0], dio_f};
        unique case (st_q)
            ST_OFF: begin
                if (enabled) begin
                    st_d = ST_START;
                end
            end
            ST_START: begin
                if (idc.done) begin
                    st_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (vrise && !dio_f) begin
                    st_d = ST_OP;
                    bit_d = 2'h0;
                end
            end
            ST_OP: begin
                if (vrise) begin
                    op_d = {op_q[0], dio_f};
                    bit_d = bit_q + 2'h1;
                    if (bit_q == 2'h1) begin
                        bit_d = 2'h0;
                        slot_d = '0;
                        if ({op_q[0], dio_f} == OP_QUERY) begin
                            st_d = ST_RESP;
                        end else if ({op_q[0], dio_f} == 2'h0) begin
                            st_d = ST_IDLE;
                        end else begin
                            st_d = ST_ARG;
                        end
                    end
                end
            end
            ST_ARG: begin
                if (vrise) begin
                    arg_d = arg_n;
                    bit_d = bit_q + 2'h1;
                    if (bit_q == 2'h2) begin
                        st_d = ST_IDLE;
                        if (op_q == OP_COUNT && arg_n != '0 &&
                            int'(arg_n) <= MAX_UNITS) begin
                            cnt_d = arg_n;
                            cfg_d = 1'b1;
                        end else if (op_q == OP_SHED && !idc.integ) begin
                            // Keeping the lowest identifiers sheds the
                            // highest first; a full count wakes all at once.
                            act_d = 3'(idc.id) < arg_n;
                        end
                    end
                end
            end
            ST_RESP: begin
                if (vrise) begin
                    slot_d = slot_q + 2'h1;
                    if (slot_q == 2'h3) begin
                        st_d = ST_IDLE;
                    end
                end
            end
        endcase
        // Reply slots are driven from the falling edge so the host sees a
        // settled level at the next rise; equal identifiers merge on the wire.
        if (fall) begin
            oe_d = st_q == ST_RESP && slot_q == idc.id;
        end
        if (!en_d) begin
            st_d = ST_OFF;
            cfg_d = 1'b0;
            act_d = 1'b1;
            oe_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_OFF;
            bit_q <= 2'h0;
            op_q <= '0;
            arg_q <= '0;
            slot_q <= '0;
            cnt_q <= '0;
            configured <= 1'b0;
            act_q <= 1'b1;
            ctrl_handshake_line_oe <= 1'b0;
            ctrl_handshake_line_o <= 1'b0;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            op_q <= op_d;
            arg_q <= arg_d;
            slot_q <= slot_d;
            cnt_q <= cnt_d;
            configured <= cfg_d;
            act_q <= act_d;
            ctrl_handshake_line_oe <= oe_d;
            ctrl_handshake_line_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Switch-node timing: one period per two timing cycles, offset by phase.

    // Offset in sixteenths of a timing period: id * 32 / count. Thirds are
    // rounded, so three units are spaced within one clock of even.
    function automatic logic [5:0] phase_num(input logic [ID_W-1:0] id,
                                            input logic [CNT_W-1:0] n);
        logic [5:0] r;
        r = 6'h00;
        unique case (n)
            3'h2: r = {id[0], 4'h0, 1'b0} >> 1;
            3'h3: r = id == 2'h1 ? 6'h0b : (id == 2'h2 ? 6'h15 : 6'h00);
            3'h4: r = {id, 3'h0} + 6'h00;
            default: r = 6'h00;
        endcase
        return r;
    endfunction

    logic half_q, half_d;
    logic [SWC_W-1:0] sw_cnt_q, sw_cnt_d;
    logic [8:0] on_cnt_q, on_cnt_d;
    logic hs_d, ls_d, run;
    logic [5:0] num;
    logic [SWC_W-1:0] offs;

    always_comb begin
        run = en_d && configured && act_q && act_clk_q;
        num = idc.integ ? 6'h00 : phase_num(idc.id, cnt_q);
        offs = SWC_W'((16'(per_q) * 16'(num)) >> 4);
        half_d = arise ? ~half_q : half_q;
        sw_cnt_d = sw_cnt_q == '1 ? sw_cnt_q : sw_cnt_q + 10'h001;
        if (arise && half_q) begin
            sw_cnt_d = '0;
        end
        hs_d = switch_node_hs;
        on_cnt_d = on_cnt_q;
        if (!run) begin
            hs_d = 1'b0;
            on_cnt_d = 9'h000;
        end else if (switch_node_hs) begin
            if (on_cnt_q <= 9'h001) begin
                hs_d = 1'b0;
                on_cnt_d = 9'h000;
            end else begin
                on_cnt_d = on_cnt_q - 9'h001;
            end
        end else if (sw_cnt_q == offs && cur_cmd != 8'h00) begin
            hs_d = 1'b1;
            on_cnt_d = {cur_cmd, 1'b0};
        end
        // Low side follows as a plain complement; dead time is analog.
        ls_d = run && !hs_d;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            half_q <= 1'b0;
            sw_cnt_q <= '1;
            on_cnt_q <= 9'h000;
            switch_node_hs <= 1'b0;
            switch_node_ls <= 1'b0;
        end else begin
            half_q <= half_d;
            sw_cnt_q <= sw_cnt_d;
            on_cnt_q <= on_cnt_d;
            switch_node_hs <= hs_d;
            switch_node_ls <= ls_d;
        end
    end
endmodule

// *** testbench/pslv_phase_ctrl_properties.sv ***
/*
 * Concurrent checks on the ports of the power slave control block.
 * Assumes one core clock domain and the asynchronous active-low reset.
 */
`timescale 1ns/1ps
module pslv_phase_ctrl_properties #(
    parameter int MAX_UNITS = pslv_pkg::UNITS_MAX
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic timing_duty_line,
    input wire logic ctrl_handshake_line_i,
    input wire logic ctrl_handshake_line_o,
    input wire logic ctrl_handshake_line_oe,
    input wire logic [pslv_pkg::ADC_W-1:0] id_adc_code,
    input wire logic id_src_en,
    input wire logic switch_node_hs,
    input wire logic switch_node_ls,
    input wire logic [pslv_pkg::MEAS_W-1:0] cur_cmd,
    input wire logic enabled,
    input wire logic configured
);
    import pslv_pkg::*;
    // Saturating counters, so long waits never wrap into a false pass.
    logic [8:0] low_q, low_d, still_q, still_d;
    logic [6:0] hs_q, hs_d;
    logic dif_q, dif_d;
    always_comb begin
        low_d = ctrl_handshake_line_i ? 9'h000 : low_q + 9'(low_q != 9'h1ff);
        dif_d = timing_duty_line;
        still_d = (timing_duty_line != dif_q) ? 9'h000 :
            still_q + 9'(still_q != 9'h1ff);
        hs_d = switch_node_hs ? hs_q + 7'(hs_q != 7'h7f) : 7'h00;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_q <= 9'h000;
            still_q <= 9'h000;
            hs_q <= 7'h00;
            dif_q <= 1'b0;
        end else begin
            low_q <= low_d;
            still_q <= still_d;
            hs_q <= hs_d;
            dif_q <= dif_d;
        end
    end
////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_RESET_QUIET: assert property ($rose(rst_b) |-> !enabled &&
        !configured && !ctrl_handshake_line_oe) else $error("busy at reset");
    AST_DRIVE_LOW_ONLY: assert property (ctrl_handshake_line_o == 1'b0)
        else $error("control line driven high");
    AST_NO_SHOOT_THRU: assert property (!(switch_node_hs && switch_node_ls))
        else $error("both switches on");
    AST_WAIT_CONFIG: assert property (!configured |->
        !switch_node_hs && !switch_node_ls) else $error("switching unconfigured");
    AST_DISABLED_IDLE: assert property (!enabled |-> !configured &&
        !ctrl_handshake_line_oe && !switch_node_hs) else $error("active off");
    AST_SRC_WHEN_ON: assert property (id_src_en |-> enabled)
        else $error("id source on while disabled");
    AST_ENABLE_ON_HIGH: assert property (ctrl_handshake_line_i [*8] |->
        enabled) else $error("enable not taken");
    AST_DISABLE_DELAY: assert property ($fell(enabled) |-> low_q >= 9'd250)
        else $error("disabled too early");
    AST_HS_WIDTH: assert property (hs_q <= 7'd56)
        else $error("high-side pulse too long");
    AST_CUR_RANGE: assert property (cur_cmd <= 8'h1b)
        else $error("current command above duty limit");
    AST_STOP_QUIET: assert property (still_q >= 9'd270 |->
        !switch_node_hs && !switch_node_ls) else $error("switching stopped line");
    COV_ENABLE: cover property ($rose(enabled));
    COV_CONFIG: cover property ($rose(configured));
    COV_SWITCH: cover property ($rose(switch_node_hs));
    COV_REPLY: cover property ($rose(ctrl_handshake_line_oe));
endmodule
bind pslv_phase_ctrl pslv_phase_ctrl_properties #(.MAX_UNITS(MAX_UNITS)) u_props (
    .clk(clk), .rst_b(rst_b), .timing_duty_line(timing_duty_line),
    .ctrl_handshake_line_i(ctrl_handshake_line_i),
    .ctrl_handshake_line_o(ctrl_handshake_line_o),
    .ctrl_handshake_line_oe(ctrl_handshake_line_oe),
    .id_adc_code(id_adc_code), .id_src_en(id_src_en),
    .switch_node_hs(switch_node_hs), .switch_node_ls(switch_node_ls),
    .cur_cmd(cur_cmd), .enabled(enabled), .configured(configured));

// *** testbench/pslv_host_model.sv ***
/*
 * Host side of the two-wire bus: makes the timing line and drives the
 * control line low or releases it. Assumes a pull-up on the control wire.
 */
`timescale 1ns/1ps
module pslv_host_model (
    input wire logic slave_oe,
    output logic timing_duty_line,
    output logic ctrl_wire
);
    import pslv_pkg::*;
    logic host_lo;
    logic seen;
    assign ctrl_wire = !(host_lo || slave_oe);
    initial begin
        timing_duty_line = 1'b0;
        host_lo = 1'b1;
        seen = 1'b1;
    end
    task line(input logic b);
        host_lo = !b;
    endtask
    // Data changes in the low phase and is read just before the rise.
    // An ideal wire has no loading skew, so the duty cycle needs no trim.
    task cyc(input int hi, input int per, input logic b);
        host_lo = !b;
        #(per - hi);
        seen = ctrl_wire;
        timing_duty_line = 1'b1;
        #(hi);
        timing_duty_line = 1'b0;
    endtask
    task frame(input logic [1:0] op, input logic [2:0] arg,
            output logic [3:0] rep);
        int i;
        rep = 4'h0;
        // Lead-in cycle: after a stopped line the first rise is refused.
        cyc(128, 256, 1'b1);
        cyc(128, 256, 1'b0);
        cyc(128, 256, op[1]);
        cyc(128, 256, op[0]);
        for (i = 0; i < 4 && op == OP_QUERY; i++) begin
            cyc(128, 256, 1'b1);
            rep[i] = !seen;
        end
        for (i = 2; i >= 0 && op[1]; i--) begin
            cyc(128, 256, arg[i]);
        end
        host_lo = 1'b0;
    endtask
endmodule

// *** testbench/pslv_phase_ctrl_tb.sv ***
/*
 * Self-checking bench of the power slave control block with a host model.
 * Assumes a 125 MHz core clock and the identifier reading set to two.
 */
`timescale 1ns/1ps
module pslv_phase_ctrl_tb;
    import pslv_pkg::*;
    logic clk, rst_b, ctrl_wire, timing, dut_o, dut_oe, src_en;
    logic hs, ls, en, cfg;
    logic [ADC_W-1:0] id_adc_code;
    logic [MEAS_W-1:0] cur_cmd;
    logic [3:0] rep;
    int mismatches;
    int cmp_count;
    pslv_phase_ctrl dut (.clk(clk), .rst_b(rst_b), .timing_duty_line(timing),
        .ctrl_handshake_line_i(ctrl_wire), .ctrl_handshake_line_o(dut_o),
        .ctrl_handshake_line_oe(dut_oe), .id_adc_code(id_adc_code),
        .id_src_en(src_en), .switch_node_hs(hs), .switch_node_ls(ls),
        .cur_cmd(cur_cmd), .enabled(en), .configured(cfg));
    pslv_host_model hm (.slave_oe(dut_oe), .timing_duty_line(timing),
        .ctrl_wire(ctrl_wire));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: got %0h expected %0h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    task t_enable;
        int n;
        @(negedge clk);
        check({en, cfg, dut_o, dut_oe, hs, ls, src_en, cur_cmd}, 0);
        hm.line(1'b1);
        for (n = 0; n < 20 && en !== 1'b1; n++) @(negedge clk);
        repeat (2) @(negedge clk);
        check(en, 1'b1);
        check(src_en, 1'b1);
        hm.frame(OP_QUERY, 3'h0, rep);
        check(rep, 4'h0);
        for (n = 0; n < 3000 && src_en !== 1'b0; n++) @(negedge clk);
        check(src_en, 1'b0);
    endtask
    task t_config;
        repeat (2) begin
            hm.frame(OP_QUERY, 3'h0, rep);
            check(rep, 4'b0100);
        end
        hm.frame(OP_COUNT, 3'h0, rep);
        check(cfg, 1'b0);
        hm.frame(OP_COUNT, 3'h5, rep);
        check(cfg, 1'b0);
        hm.frame(OP_COUNT, 3'h3, rep);
        check(cfg, 1'b1);
    endtask
    // Pulse width and spacing are counted on falling edges to avoid races.
    task t_switch;
        int w, p;
        w = 0;
        p = 0;
        fork
            repeat (14) hm.cyc(128, 256, 1'b1);
            begin
                for (w = 0; w < 100 && hs === 1'b1; w++) @(negedge clk);
                for (p = 0; p < 400 && hs !== 1'b1; p++) @(negedge clk);
                for (w = 0; w < 100 && hs === 1'b1; w++) @(negedge clk);
                for (p = w; p < 200 && hs !== 1'b1; p++) @(negedge clk);
            end
        join
        check(w, 32);
        check(p, 64);
        check(cur_cmd, 8'h10);
        repeat (4) hm.cyc(64, 256, 1'b1);
        check(cur_cmd, 8'h08);
        repeat (3) hm.cyc(32, 256, 1'b1);
        check(cur_cmd, 8'h08);
        repeat (6) hm.cyc(56, 120, 1'b1);
        check(cur_cmd, 8'h08);
    endtask
    task t_idle;
        int n;
        repeat (3) hm.cyc(496, 1000, 1'b1);
        @(negedge clk);
        check({hs, ls}, 2'b00);
        fork
            repeat (8) hm.cyc(128, 256, 1'b1);
            for (n = 0; n < 300 && hs !== 1'b1; n++) @(negedge clk);
        join
        check(n < 300, 1'b1);
    endtask
    task t_disable;
        hm.line(1'b0);
        repeat (200) @(negedge clk);
        check(en, 1'b1);
        repeat (100) @(negedge clk);
        check({en, cfg, dut_oe, hs}, 4'h0);
    endtask
    task t_shed;
        int n;
        hm.frame(OP_SHED, 3'h2, rep);
        fork
            repeat (8) hm.cyc(128, 256, 1'b1);
            for (n = 0; n < 250 && hs !== 1'b1; n++) @(negedge clk);
        join
        check(n, 250);
        hm.frame(OP_SHED, 3'h4, rep);
        fork
            repeat (8) hm.cyc(128, 256, 1'b1);
            for (n = 0; n < 300 && hs !== 1'b1; n++) @(negedge clk);
        join
        check(n < 300, 1'b1);
    endtask
    // Second reset in integrated-controller mode with one shared identifier.
    task t_integ;
        int n;
        @(posedge clk);
        rst_b <= 1'b0;
        id_adc_code <= 8'he0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        hm.line(1'b1);
        repeat (2600) @(negedge clk);
        check({en, src_en}, 2'b10);
        hm.frame(OP_QUERY, 3'h0, rep);
        check(rep, 4'b0001);
        hm.frame(OP_COUNT, 3'h3, rep);
        hm.frame(OP_SHED, 3'h0, rep);
        fork
            repeat (8) hm.cyc(128, 256, 1'b1);
            for (n = 0; n < 300 && hs !== 1'b1; n++) @(negedge clk);
        join
        check(n < 300, 1'b1);
    endtask
    initial begin
        #200000;
        mismatches++;
        end_of_test;
    end
    initial begin
        rst_b = 1'b0;
        id_adc_code = 8'h40;
        mismatches = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_enable;
        t_config;
        t_switch;
        t_idle;
        t_shed;
        t_disable;
        t_integ;
        end_of_test;
    end
endmodule
